// [ext_irq_pkg.sv]
// package: constants, types and behaviour list for the external interrupt and stop block
// Behaviour
// - a vector is loaded only for an occurred request with global enable set
// - all port-pin requests go to vector one or vector two only
// - vector one is edge or level sensitive per the level/edge select bit
// - vector two is always edge sensitive; polarity bit set means rising edge
// - an active edge sets a latch, cleared when its service routine starts
// - an edge during service stays pending; further edges are not counted
// - level mode stores nothing; line low at instruction end makes a request
// - switching vector two to rising with an enabled pin latches a request
// - falling mode: one enabled vector two pin held low blocks the others
// - rising mode: one enabled vector two pin held high blocks the others
// - enabling a low vector two pin with polarity clear latches a request
// - disabling a low vector two pin with polarity set latches a request
// - stop halts execution and the oscillator, keeping all register contents
// - stop is left on reset, external or nmi interrupt, or peripheral interrupt
// - every stop exit waits 2048 internal clocks before execution resumes
// - after the delay the routine of the waking cause is entered
// - with watchdog active stop acts as wait, unless option set and nmi high
package ext_irq_pkg;
   localparam int unsigned V1_PINS = 4;
   localparam int unsigned V2_PINS = 4;
   // register byte offsets
   localparam logic [7:0] OFS_OPTION = 8'h00;
   localparam logic [7:0] OFS_PINCFG = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MASK   = 8'h0C;
   localparam logic [7:0] OFS_STATE  = 8'h10;
   // reset values
   localparam logic [3:0] OPTION_RST = 4'h0;
   localparam logic [7:0] PINCFG_RST = 8'h00;
   localparam logic [2:0] MASK_RST   = 3'h0;
   // status bit positions
   localparam int unsigned ST_V1   = 0;
   localparam int unsigned ST_V2   = 1;
   localparam int unsigned ST_WAKE = 2;
   // oscillator settle time, in internal clock cycles
   localparam int unsigned WAKE_DELAY_CYC = 2048;
   localparam logic [11:0] WAKE_LOAD      = 12'(WAKE_DELAY_CYC - 1);
   typedef enum logic [3:0] {
      RUN      = 4'h1,
      STOPPED  = 4'h2,
      WAKING   = 4'h4,
      WAITING  = 4'h8
   } pwr_state_type;
   typedef enum logic [1:0] {
      CAUSE_NONE   = 2'h0,
      CAUSE_RESET  = 2'h1,
      CAUSE_EXT    = 2'h2,
      CAUSE_PERIPH = 2'h3
   } cause_type;
   typedef struct packed {
      logic stop_under_watchdog_option;
      logic edge_polarity_select;
      logic level_edge_select;
      logic global_ext_irq_enable;
   } option_type;
   typedef struct packed {
      logic [V2_PINS-1:0] v2_irq_en;
      logic [V1_PINS-1:0] v1_irq_en;
   } pincfg_type;
endpackage : ext_irq_pkg

// [ext_irq_stop.sv]
// module: external interrupt front end, vector dispatch and stop/wake sequencer
module ext_irq_stop (
   input  wire logic                            CORE_CLK,
   input  wire logic                            SYS_RST,
   input  wire logic                            WB_CYC_I,
   input  wire logic                            WB_STB_I,
   input  wire logic                            WB_WE_I,
   input  wire logic [7:0]                      WB_ADR_I,
   input  wire logic [3:0]                      WB_SEL_I,
   input  wire logic [31:0]                     WB_DAT_I,
   output logic      [31:0]                     WB_DAT_O,
   output logic                                 WB_ACK_O,
   input  wire logic [ext_irq_pkg::V1_PINS-1:0] V1_PIN,
   input  wire logic [ext_irq_pkg::V2_PINS-1:0] V2_PIN,
   input  wire logic                            INSTR_DONE,
   input  wire logic                            SVC_DONE,
   input  wire logic                            STOP_EXEC,
   input  wire logic                            WDOG_ACTIVE,
   input  wire logic                            NMI_PIN,
   input  wire logic                            NMI_IRQ,
   input  wire logic                            PERIPH_IRQ,
   input  wire logic                            RESET_REQ,
   output logic                                 PC_LOAD,
   output logic      [1:0]                      PC_VECTOR,
   output logic                                 IN_SERVICE,
   output logic                                 CPU_HALT,
   output logic                                 OSC_ENABLE,
   output logic                                 WDOG_FREEZE,
   output logic                                 WAKE_DONE,
   output ext_irq_pkg::cause_type               WAKE_CAUSE,
   output logic                                 IRQ
);
   import ext_irq_pkg::*;

   option_type    opt;
   pincfg_type    pcfg;
   logic [2:0]    status;
   logic [2:0]    mask;
   pwr_state_type state;
   logic [11:0]   delay_cnt;
   cause_type     cause;
   logic          v1_latch;
   logic          v2_latch;
   logic          v1_low_prev;
   logic          v2_low_prev;
   logic          v2_high_prev;
   logic          wdog_held;

   // any enabled pin at the given level; models the wired line of a vector
   function automatic logic any_at(input logic [3:0] pins, input logic [3:0] en,
                                   input logic level);
      any_at = level ? |(pins & en) : |(~pins & en);
   endfunction : any_at

   // bus decode; write and read-clear act at the edge where ack is high
   logic req;
   logic wr_take;
   logic rd_take;
   assign req     = WB_CYC_I & WB_STB_I;
   assign wr_take = req & WB_ACK_O & WB_WE_I & WB_SEL_I[0];
   assign rd_take = req & WB_ACK_O & ~WB_WE_I;

   option_type next_opt;
   pincfg_type next_pcfg;
   assign next_opt  = option_type'(WB_DAT_I[3:0]);
   assign next_pcfg = pincfg_type'(WB_DAT_I[7:0]);

   // wired lines of both vectors
   logic v1_low;
   logic v2_low;
   logic v2_high;
   assign v1_low  = any_at(V1_PIN, pcfg.v1_irq_en, 1'b0);
   assign v2_low  = any_at(V2_PIN, pcfg.v2_irq_en, 1'b0);
   assign v2_high = any_at(V2_PIN, pcfg.v2_irq_en, 1'b1);

   // a line edge only shows when no other enabled pin already holds the line
   logic v1_edge;
   logic v2_edge;
   assign v1_edge = v1_low & ~v1_low_prev;
   assign v2_edge = opt.edge_polarity_select ? (v2_high & ~v2_high_prev)
                                             : (v2_low & ~v2_low_prev);

   // configuration side effects of the vector two circuitry
   logic v2_spur;
   logic [3:0] v2_newly_on;
   logic [3:0] v2_newly_off;
   assign v2_newly_on  = next_pcfg.v2_irq_en & ~pcfg.v2_irq_en;
   assign v2_newly_off = ~next_pcfg.v2_irq_en & pcfg.v2_irq_en;
   always_comb begin
      v2_spur = 1'b0;
      if (wr_take && WB_ADR_I == OFS_OPTION && next_opt.edge_polarity_select
          && !opt.edge_polarity_select && |pcfg.v2_irq_en) begin
         v2_spur = 1'b1;
      end
      if (wr_take && WB_ADR_I == OFS_PINCFG) begin
         if (!opt.edge_polarity_select && |(v2_newly_on & ~V2_PIN)) begin
            v2_spur = 1'b1;
         end
         if (opt.edge_polarity_select && |(v2_newly_off & ~V2_PIN)) begin
            v2_spur = 1'b1;
         end
      end
   end

   // vector one request: stored latch in edge mode, live line in level mode
   logic v1_req;
   assign v1_req = opt.level_edge_select ? v1_latch : v1_low;

   // dispatch point: end of an instruction, or end of a wake delay caused by an external or nmi interrupt
   logic wake_end;
   logic sample;
   logic take_v1;
   logic take_v2;
   assign wake_end = (state == WAKING) && (delay_cnt == 12'h000);
   assign sample   = ((state == RUN) && INSTR_DONE) || (wake_end && cause == CAUSE_EXT);
   assign take_v1  = sample && opt.global_ext_irq_enable && !IN_SERVICE && v1_req;
   assign take_v2  = sample && opt.global_ext_irq_enable && !IN_SERVICE && !v1_req
                     && v2_latch;

   // edge latches hold one request each; a new edge wins over the clear
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         v1_latch <= 1'b0;
         v2_latch <= 1'b0;
      end else begin
         if (v1_edge && opt.level_edge_select) begin
            v1_latch <= 1'b1;
         end else if (take_v1 || !opt.level_edge_select) begin
            v1_latch <= 1'b0;
         end
         if (v2_edge || v2_spur) begin
            v2_latch <= 1'b1;
         end else if (take_v2) begin
            v2_latch <= 1'b0;
         end
      end
   end

   // previous line levels for edge detection
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         v1_low_prev  <= 1'b0;
         v2_low_prev  <= 1'b0;
         v2_high_prev <= 1'b0;
      end else begin
         v1_low_prev  <= v1_low;
         v2_low_prev  <= v2_low;
         v2_high_prev <= v2_high;
      end
   end

   // vector load toward the core; service ends on return from interrupt
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         PC_LOAD    <= 1'b0;
         PC_VECTOR  <= 2'h0;
         IN_SERVICE <= 1'b0;
      end else begin
         PC_LOAD <= take_v1 || take_v2;
         if (take_v1) begin
            PC_VECTOR  <= 2'h1;
            IN_SERVICE <= 1'b1;
         end else if (take_v2) begin
            PC_VECTOR  <= 2'h2;
            IN_SERVICE <= 1'b1;
         end else if (SVC_DONE) begin
            IN_SERVICE <= 1'b0;
         end
      end
   end

   // wake sources, reset first since it overrides any pending routine
   logic ext_wake;
   logic any_wake;
   logic stop_ok;
   assign ext_wake = v1_req || v2_latch || v2_edge || NMI_IRQ;
   assign any_wake = RESET_REQ || ext_wake || PERIPH_IRQ;
   assign stop_ok  = !WDOG_ACTIVE || (opt.stop_under_watchdog_option && NMI_PIN);

   // power sequencer; the core clock keeps running here to count the delay
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state     <= RUN;
         delay_cnt <= 12'h000;
         cause     <= CAUSE_NONE;
         wdog_held <= 1'b0;
      end else begin
         case (state)
            RUN: begin
               if (STOP_EXEC && stop_ok) begin
                  state     <= STOPPED;
                  wdog_held <= WDOG_ACTIVE;
               end else if (STOP_EXEC) begin
                  state <= WAITING;
               end
            end
            STOPPED: begin
               if (any_wake) begin
                  state     <= WAKING;
                  delay_cnt <= WAKE_LOAD;
                  if (RESET_REQ) begin
                     cause <= CAUSE_RESET;
                  end else if (ext_wake) begin
                     cause <= CAUSE_EXT;
                  end else begin
                     cause <= CAUSE_PERIPH;
                  end
               end
            end
            WAKING: begin
               if (delay_cnt == 12'h000) begin
                  state     <= RUN;
                  wdog_held <= 1'b0;
               end else begin
                  delay_cnt <= delay_cnt - 12'h001;
               end
            end
            WAITING: begin
               // wait keeps the oscillator, so no settle delay
               if (any_wake) begin
                  state <= RUN;
               end
            end
            default: begin
               state <= RUN;
            end
         endcase
      end
   end

   // wake report toward the core and reset logic
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         WAKE_DONE  <= 1'b0;
         WAKE_CAUSE <= CAUSE_NONE;
      end else begin
         WAKE_DONE <= wake_end;
         if (wake_end) begin
            WAKE_CAUSE <= cause;
         end
      end
   end

   assign CPU_HALT    = (state != RUN);
   assign OSC_ENABLE  = (state != STOPPED);
   assign WDOG_FREEZE = wdog_held;

   // software registers; pins and latches are not touched by stop
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         opt  <= option_type'(OPTION_RST);
         pcfg <= pincfg_type'(PINCFG_RST);
         mask <= MASK_RST;
      end else if (wr_take) begin
         case (WB_ADR_I)
            OFS_OPTION: opt  <= next_opt;
            OFS_PINCFG: pcfg <= next_pcfg;
            OFS_MASK:   mask <= WB_DAT_I[2:0];
            default:    mask <= mask;
         endcase
      end
   end

   // sticky status; a read clears only what it returned, so new events survive
   logic [2:0] events;
   assign events = {wake_end, take_v2, take_v1};
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         status <= 3'h0;
      end else if (rd_take && WB_ADR_I == OFS_STATUS) begin
         status <= (status & ~WB_DAT_O[2:0]) | events;
      end else begin
         status <= status | events;
      end
   end

   assign IRQ = |(status & mask);

   // read mux, answered one cycle after the request; unmapped reads as zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (WB_ADR_I)
         OFS_OPTION: rd_mux[3:0] = opt;
         OFS_PINCFG: rd_mux[7:0] = pcfg;
         OFS_STATUS: rd_mux[2:0] = status;
         OFS_MASK:   rd_mux[2:0] = mask;
         OFS_STATE:  rd_mux[9:0] = {cause, wdog_held, IN_SERVICE, v2_latch, v1_latch, state};
         default:    rd_mux      = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= req & ~WB_ACK_O;
         if (req && !WB_ACK_O) begin
            WB_DAT_O <= rd_mux;
         end
      end
   end

   // helper: cycles spent in the wake delay
   logic [12:0] wake_len;
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || state != WAKING) begin
         wake_len <= 13'h0000;
      end else begin
         wake_len <= wake_len + 13'h0001;
      end
   end

   // helper: a reset request taken in stop, remembered until its wake report
   logic reset_woke;
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || WAKE_DONE) begin
         reset_woke <= 1'b0;
      end else if (state == STOPPED && RESET_REQ) begin
         reset_woke <= 1'b1;
      end
   end

   localparam int WAKE_LAST = WAKE_DELAY_CYC - 1;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   chk_load_needs_enable: assert property (
      PC_LOAD |-> $past(opt.global_ext_irq_enable) && !$past(IN_SERVICE))
      else $error("vector loaded without global enable");

   chk_two_vectors: assert property (
      PC_LOAD |-> (PC_VECTOR == 2'h1 || PC_VECTOR == 2'h2))
      else $error("vector code out of range");

   chk_level_live: assert property (
      PC_LOAD && PC_VECTOR == 2'h1 && !$past(opt.level_edge_select) |-> $past(v1_low))
      else $error("level request taken with line high");

   chk_edge_sets: assert property (
      v2_edge |=> v2_latch)
      else $error("vector two edge not latched");

   chk_start_clears: assert property (
      take_v2 && !v2_edge && !v2_spur |=> !v2_latch && PC_LOAD && PC_VECTOR == 2'h2)
      else $error("latch not cleared at routine start");

   chk_pending_held: assert property (
      v2_latch && IN_SERVICE |=> v2_latch)
      else $error("pending request lost during service");

   chk_stop_halts: assert property (
      state == RUN && STOP_EXEC && stop_ok |=> (!OSC_ENABLE && CPU_HALT)
      throughout (state == STOPPED)[*1])
      else $error("stop did not halt oscillator");

   chk_wake_delay: assert property (
      $fell(state == WAKING) |-> $past(wake_len) == WAKE_LAST)
      else $error("wake delay length wrong");

   chk_wake_report: assert property (
      WAKE_DONE && reset_woke |-> WAKE_CAUSE == CAUSE_RESET
      && wake_len == 13'(WAKE_DELAY_CYC))
      else $error("reset wake not reported after delay");

   chk_wdog_wait: assert property (
      state == RUN && STOP_EXEC && WDOG_ACTIVE
      && !(opt.stop_under_watchdog_option && NMI_PIN) |=> state == WAITING && OSC_ENABLE)
      else $error("stop under watchdog not taken as wait");

   chk_rising_spur: assert property (
      v2_spur |=> v2_latch)
      else $error("spurious vector two request not latched");

   chk_reset_clears: assert property (@(posedge CORE_CLK) disable iff (1'b0)
      SYS_RST |=> !v1_latch && !v2_latch && !IN_SERVICE)
      else $error("reset left a pending latch");

endmodule : ext_irq_stop

// [port_pin_model.sv]
// partner model: port pins with pull-ups, pulled low on command
module port_pin_model (
   input  wire logic [7:0] pull_low,
   output logic      [3:0] v1_level,
   output logic      [3:0] v2_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pin rises to its pull-up, it never keeps a stale level
   assign v1_level = ~pull_low[3:0];
   assign v2_level = ~pull_low[7:4];
endmodule : port_pin_model

// [tb_top.sv]
// testbench: bus, pin and core stimulus with queued expectations
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ext_irq_pkg::*;
   localparam int EV_INSTR = 0, EV_SVC = 1, EV_STOP = 2, EV_PERI = 3, EV_RSTQ = 4, EV_NMI = 5;
   logic        core_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0]  adr = '0, pull_low = '0;
   logic [3:0]  sel = '0, wsel = 4'hF, v1_pin, v2_pin;
   logic [31:0] wdat = '0, wb_dat, rnd;
   logic [5:0]  ev = '0;
   wire         instr_done = ev[EV_INSTR], svc_done = ev[EV_SVC], stop_exec = ev[EV_STOP];
   wire         periph_irq = ev[EV_PERI], reset_req = ev[EV_RSTQ], nmi_irq = ev[EV_NMI];
   logic        wdog_active = 0, nmi_pin = 0, wb_ack, pc_load, in_service, cpu_halt;
   logic        osc_enable, wdog_freeze, wake_done, irq;
   logic [1:0]  pc_vector;
   cause_type   wake_cause;
   int          miscompares = 0, checks_done = 0, wake_cnt = 0, guard;
   integer      seed = 32'h5D00;
   logic [1:0]  exp_vec[$];
   logic [63:0] exp_rd[$];
   logic [63:0] rd_note;
   cause_type   exp_cause[$];
   cause_type   cause_tab[3] = '{CAUSE_PERIPH, CAUSE_EXT, CAUSE_RESET};

   port_pin_model pins (.pull_low(pull_low), .v1_level(v1_pin), .v2_level(v2_pin));
   ext_irq_stop dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(wb_dat),
      .WB_ACK_O(wb_ack), .V1_PIN(v1_pin), .V2_PIN(v2_pin), .INSTR_DONE(instr_done),
      .SVC_DONE(svc_done), .STOP_EXEC(stop_exec), .WDOG_ACTIVE(wdog_active),
      .NMI_PIN(nmi_pin), .NMI_IRQ(nmi_irq), .PERIPH_IRQ(periph_irq), .RESET_REQ(reset_req),
      .PC_LOAD(pc_load), .PC_VECTOR(pc_vector), .IN_SERVICE(in_service),
      .CPU_HALT(cpu_halt), .OSC_ENABLE(osc_enable), .WDOG_FREEZE(wdog_freeze),
      .WAKE_DONE(wake_done), .WAKE_CAUSE(wake_cause), .IRQ(irq));

   // 40 ns period
   initial begin
      forever #20 core_clk = ~core_clk;
   end

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   // classic cycle, held until ack is sampled, then one idle cycle
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= wsel;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack !== 1'b1);
      cyc <= 0; stb <= 0; we <= 0;
      check("ack latency", 32'(n), 32'h2);
   endtask : wb

   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
      exp_rd.push_back({m, e});
      wb(1'b0, a, 32'h0);
   endtask : rd

   task pulse(input int k);
      @(posedge core_clk);
      ev <= 6'(1 << k);
      @(posedge core_clk);
      ev <= '0;
      repeat (3) @(posedge core_clk);
   endtask : pulse

   task pin(input int p, input logic low);
      @(posedge core_clk);
      pull_low[p] <= low;
      repeat (3) @(posedge core_clk);
   endtask : pin

   // monitor: each observed result consumes the oldest note
   always @(posedge core_clk) begin
      if (cpu_halt === 1'b1 && osc_enable === 1'b1) wake_cnt++;
      if (pc_load === 1'b1)
         check("vector", 32'(pc_vector), exp_vec.size() ? 32'(exp_vec.pop_front()) : 32'hFF);
      if (wake_done === 1'b1) begin
         check("wake delay", 32'(wake_cnt), 32'(WAKE_DELAY_CYC));
         check("wake cause", 32'(wake_cause),
               exp_cause.size() ? 32'(exp_cause.pop_front()) : 32'hFF);
      end
      if (wb_ack === 1'b1 && we === 1'b0 && exp_rd.size()) begin
         rd_note = exp_rd.pop_front();
         check("read", wb_dat & rd_note[63:32], rd_note[31:0]);
      end
   end

   // about 7000 cycles expected; three wake delays dominate
   initial begin
      repeat (15000) @(posedge core_clk);
      miscompares++;
      print_verdict();
   end

   initial begin
      repeat (3) @(posedge core_clk);
      sys_rst <= 0;
      rd(OFS_OPTION, 32'(OPTION_RST));
      rd(OFS_PINCFG, 32'(PINCFG_RST));
      rd(OFS_MASK, 32'(MASK_RST));
      rd(OFS_STATE, 32'h1, 32'hFF);
      rd(8'h20, 32'h0);
      rnd = $random(seed);
      wb(1'b1, OFS_MASK, rnd);
      rd(OFS_MASK, rnd & 32'h7);
      // a write without its low byte lane selected leaves the register alone
      wsel = 4'hE;
      wb(1'b1, OFS_MASK, ~rnd);
      wsel = 4'hF;
      rd(OFS_MASK, rnd & 32'h7);
      wb(1'b1, OFS_MASK, 32'h0);
      $display("test registers done");
      // edge on vector two with global enable off, then on
      wb(1'b1, OFS_OPTION, 32'h2);
      wb(1'b1, OFS_PINCFG, 32'h10);
      pin(4, 1);
      pulse(EV_INSTR);
      wb(1'b1, OFS_OPTION, 32'h3);
      exp_vec.push_back(2'd2);
      pulse(EV_INSTR);
      check("in service", 32'(in_service), 32'h1);
      pin(4, 0); pin(4, 1); pin(4, 0); pin(4, 1);
      pulse(EV_INSTR);
      pulse(EV_SVC);
      exp_vec.push_back(2'd2);
      pulse(EV_INSTR);
      pulse(EV_INSTR);
      pulse(EV_SVC);
      check("pending loads", 32'(exp_vec.size()), 32'h0);
      pin(4, 0);
      $display("test edge latch done");
      // level mode stores nothing; edge mode stores one
      wb(1'b1, OFS_OPTION, 32'h1);
      wb(1'b1, OFS_PINCFG, 32'h01);
      pin(0, 1); pin(0, 0);
      pulse(EV_INSTR);
      pin(0, 1);
      exp_vec.push_back(2'd1);
      pulse(EV_INSTR);
      pin(0, 0);
      pulse(EV_SVC);
      wb(1'b1, OFS_OPTION, 32'h3);
      pin(0, 1); pin(0, 0);
      exp_vec.push_back(2'd1);
      pulse(EV_INSTR);
      pulse(EV_SVC);
      $display("test vector one done");
      // one pin held low masks the other in falling mode
      wb(1'b1, OFS_PINCFG, 32'h30);
      exp_vec.push_back(2'd2);
      pin(4, 1);
      pulse(EV_INSTR);
      pulse(EV_SVC);
      pin(5, 1);
      pulse(EV_INSTR);
      pin(4, 0); pin(5, 0);
      // spurious requests on reconfiguration
      wb(1'b1, OFS_PINCFG, 32'h0);
      pin(4, 1);
      exp_vec.push_back(2'd2);
      wb(1'b1, OFS_PINCFG, 32'h10);
      pulse(EV_INSTR); pulse(EV_SVC);
      exp_vec.push_back(2'd2);
      wb(1'b1, OFS_OPTION, 32'h7);
      pulse(EV_INSTR); pulse(EV_SVC);
      exp_vec.push_back(2'd2);
      wb(1'b1, OFS_PINCFG, 32'h0);
      pulse(EV_INSTR); pulse(EV_SVC);
      pin(4, 0);
      // rising mode: one pin held high masks the other
      wb(1'b1, OFS_OPTION, 32'h3);
      wb(1'b1, OFS_PINCFG, 32'h30);
      exp_vec.push_back(2'd2);
      wb(1'b1, OFS_OPTION, 32'h7);
      pulse(EV_INSTR); pulse(EV_SVC);
      pin(5, 1); pin(5, 0);
      pulse(EV_INSTR);
      wb(1'b1, OFS_PINCFG, 32'h10);
      wb(1'b1, OFS_OPTION, 32'h3);
      rd(OFS_STATUS, 32'h3);
      wb(1'b1, OFS_MASK, 32'h4);
      $display("test vector two quirks done");
      // stop and wake by each kind of source; last one with frozen watchdog
      for (int i = 0; i < 3; i++) begin
         if (i == 2) begin
            wdog_active <= 1; nmi_pin <= 1;
            wb(1'b1, OFS_OPTION, 32'hB);
            wb(1'b1, OFS_MASK, 32'h0);
         end
         wake_cnt = 0;
         pulse(EV_STOP);
         check("osc", 32'(osc_enable), 32'h0);
         check("halt", 32'(cpu_halt), 32'h1);
         check("freeze", 32'(wdog_freeze), 32'(i == 2));
         rd(OFS_STATE, (i == 2) ? 32'h82 : 32'h2, 32'hFF);
         exp_cause.push_back(cause_tab[i]);
         if (i == 1) exp_vec.push_back(2'd2);
         case (i)
            0: pulse(EV_PERI);
            1: pin(4, 1);
            default: pulse(EV_RSTQ);
         endcase
         guard = 0;
         while (exp_cause.size() != 0 && guard < 3000) begin
            @(posedge core_clk);
            guard++;
         end
         repeat (3) @(posedge core_clk);
         check("irq", 32'(irq), 32'(i != 2));
         rd(OFS_STATUS, (i == 1) ? 32'h6 : 32'h4);
         repeat (2) @(posedge core_clk);
         check("irq clear", 32'(irq), 32'h0);
         if (i == 1) begin
            pin(4, 0);
            pulse(EV_SVC);
         end
      end
      // watchdog running without the option: stop behaves as wait
      nmi_pin <= 0;
      wb(1'b1, OFS_OPTION, 32'h3);
      pulse(EV_STOP);
      check("wait osc", 32'(osc_enable), 32'h1);
      rd(OFS_STATE, 32'h8, 32'hFF);
      pulse(EV_NMI);
      rd(OFS_STATE, 32'h1, 32'hFF);
      wdog_active <= 0;
      $display("test stop and wake done");
      // a pending latch does not survive a system reset
      wb(1'b1, OFS_OPTION, 32'h2);
      pin(4, 1);
      rd(OFS_STATE, 32'h21, 32'hFF);
      @(posedge core_clk);
      sys_rst <= 1;
      @(posedge core_clk);
      sys_rst <= 0;
      rd(OFS_STATE, 32'h1, 32'hFF);
      pin(4, 0);
      $display("test reset clear done");
      check("queues", 32'(exp_vec.size() + exp_rd.size() + exp_cause.size()), 32'h0);
      print_verdict();
   end
endmodule : tb_top
